// [verilog/autoneg_np_defs.svh]
`ifndef AUTONEG_NP_DEFS_SVH
`define AUTONEG_NP_DEFS_SVH

// Register offsets on the management port
`define AN_EXPANSION_OFFSET 5'h06
`define NP_TRANSMIT_OFFSET 5'h07
`define PARTNER_NP_OFFSET 5'h08

// Expansion status field positions
`define EXP_BASE_PAGE_BIT 5
`define EXP_PAR_FAULT_BIT 4
`define EXP_LP_NP_ABLE_BIT 3
`define EXP_NP_ABLE_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_LP_AN_ABLE_BIT 0

// Next-page word field positions (transmit and receive share them)
`define NPW_MORE_PAGES_BIT 15
`define NPW_ACK_BIT 14
`define NPW_MSG_FMT_BIT 13
`define NPW_COMPLY_BIT 12
`define NPW_TOGGLE_BIT 11
`define NPW_CODE_MSB 10

// Reset values
`define RST_MORE_PAGES 1'b0
`define RST_MSG_FMT 1'b1
`define RST_COMPLY 1'b0
`define RST_TOGGLE 1'b0
`define RST_CODE 11'h001
`define RST_NP_ABLE 1'b1
`define RST_WORD 16'h0000

`endif

// [verilog/autoneg_np_pkg.sv]
`default_nettype none

package autoneg_np_pkg;

  // One 16-bit management register word
  typedef logic [15:0] reg_word_t;

  // Management register address
  typedef logic [4:0] reg_addr_t;

  // Kind of the page just received
  typedef enum logic {
    PAGE_BASE,
    PAGE_NEXT
  } page_kind_t;

endpackage

`default_nettype wire

// [verilog/latch_high_flag.sv]
`timescale 1ns/1ps
`default_nettype none

// Sticky status bit: an event sets it, a clear drops it, set beats clear
module latch_high_flag (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic set_evt,
  input wire logic clr_evt,
  // State
  output logic flag_r
);

  // Set wins so an event in the clearing cycle is never lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (clr_evt) begin
      flag_r <= 1'b0;
    end
  end

endmodule // latch_high_flag

`default_nettype wire

// [verilog/autoneg_np_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_np_defs.svh"

module autoneg_np_regs #(
  parameter int CODE_W = 11
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Management register port
  input wire autoneg_np_pkg::reg_addr_t mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire autoneg_np_pkg::reg_word_t mgmt_wdata,
  output autoneg_np_pkg::reg_word_t mgmt_rdata_r,
  // Configuration from the vendor register
  input wire logic alternate_next_page_enable,
  input wire logic transmit_disable,
  // Arbitration engine status
  input wire logic page_arrived_variable,
  input wire logic base_page_variable,
  input wire logic parallel_fault_evt,
  input wire logic partner_np_able,
  input wire logic partner_an_able,
  // Received page from the engine
  input wire logic rx_page_stb,
  input wire autoneg_np_pkg::page_kind_t rx_page_kind,
  input wire autoneg_np_pkg::reg_word_t rx_page_word,
  // Transmit page toward the engine
  input wire logic tx_page_sent,
  output autoneg_np_pkg::reg_word_t tx_page_word_r,
  output logic tx_page_loaded_r,
  // Partner base page store
  output autoneg_np_pkg::reg_word_t partner_base_word_r
);
  import autoneg_np_pkg::*;

  // Code field width is fixed by the word layout, refused at elaboration
  if (CODE_W != `NPW_CODE_MSB + 1) begin : g_code_w_check
    $error("CODE_W must match the next-page code field");
  end

  // Address match helper
  function automatic logic addr_hit(input reg_addr_t a, input reg_addr_t off);
    addr_hit = (a == off);
  endfunction

  // Access decode
  logic rd_expansion; // Read of expansion register
  logic wr_transmit; // Write of transmit register
  assign rd_expansion = mgmt_rd && addr_hit(mgmt_addr, `AN_EXPANSION_OFFSET);
  assign wr_transmit = mgmt_wr && addr_hit(mgmt_addr, `NP_TRANSMIT_OFFSET);

  // Latched status bits
  logic base_page_r; // Base page seen
  logic par_fault_r; // Parallel detection fault seen
  logic page_rx_r; // New page received
  logic base_set; // Base flag set term
  logic base_clr; // Base flag clear term
  logic page_rx_clr; // Page-received clear term

  // Base flag only sets while the alternate feature is on
  assign base_set = alternate_next_page_enable && base_page_variable;
  // Cleared by a read, and held at 0 while the feature is off
  assign base_clr = rd_expansion || !alternate_next_page_enable;
  // Read clears; alternate mode adds engine-driven clears
  assign page_rx_clr = rd_expansion
                       || (alternate_next_page_enable
                           && (!page_arrived_variable || transmit_disable));

  // Base page flag
  latch_high_flag u_base_flag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_evt(base_set),
    .clr_evt(base_clr),
    .flag_r(base_page_r)
  );

  // Parallel detection fault flag
  latch_high_flag u_fault_flag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_evt(parallel_fault_evt),
    .clr_evt(rd_expansion),
    .flag_r(par_fault_r)
  );

  // Page received flag
  latch_high_flag u_page_flag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_evt(rx_page_stb),
    .clr_evt(page_rx_clr),
    .flag_r(page_rx_r)
  );

  // Live partner ability bits and the fixed local one
  logic lp_np_able_r; // Partner next-page able
  logic lp_an_able_r; // Partner auto-negotiation able
  logic local_np_able_r; // Local next-page able

  // Registered partner abilities, cleared at reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_np_able_r <= 1'b0;
      lp_an_able_r <= 1'b0;
    end else begin
      lp_np_able_r <= partner_np_able;
      lp_an_able_r <= partner_an_able;
    end
  end

  // Local ability is fixed; it only exists to read back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_np_able_r <= `RST_NP_ABLE;
    end else begin
      local_np_able_r <= `RST_NP_ABLE;
    end
  end

  // Transmit next-page fields
  logic more_pages_follow_r; // Further pages follow
  logic message_format_select_r; // Message page format
  logic can_comply_flag_r; // Local station complies
  logic toggle_r; // Toggle to send next
  logic [CODE_W-1:0] code_r; // Message or user code

  // Writable fields of the transmit register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      more_pages_follow_r <= `RST_MORE_PAGES;
      message_format_select_r <= `RST_MSG_FMT;
      can_comply_flag_r <= `RST_COMPLY;
      code_r <= `RST_CODE;
    end else if (wr_transmit) begin
      more_pages_follow_r <= mgmt_wdata[`NPW_MORE_PAGES_BIT];
      message_format_select_r <= mgmt_wdata[`NPW_MSG_FMT_BIT];
      can_comply_flag_r <= mgmt_wdata[`NPW_COMPLY_BIT];
      code_r <= mgmt_wdata[`NPW_CODE_MSB:0];
    end
  end

  // Toggle flips after each word goes out; a send beats a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= `RST_TOGGLE;
    end else if (tx_page_sent) begin
      toggle_r <= !toggle_r;
    end else if (wr_transmit) begin
      toggle_r <= mgmt_wdata[`NPW_TOGGLE_BIT];
    end
  end

  // Word handed to the engine; the reserved bit stays 0
  reg_word_t tx_word_nxt; // Assembled transmit word
  always_comb begin
    tx_word_nxt = `RST_WORD;
    tx_word_nxt[`NPW_MORE_PAGES_BIT] = more_pages_follow_r;
    tx_word_nxt[`NPW_MSG_FMT_BIT] = message_format_select_r;
    tx_word_nxt[`NPW_COMPLY_BIT] = can_comply_flag_r;
    tx_word_nxt[`NPW_TOGGLE_BIT] = toggle_r;
    tx_word_nxt[`NPW_CODE_MSB:0] = code_r;
  end

  // Transmit word and the loaded pulse to the engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Register defaults, so the engine never sees an empty word in reset
      tx_page_word_r <= {`RST_MORE_PAGES, 1'b0, `RST_MSG_FMT, `RST_COMPLY, `RST_TOGGLE, `RST_CODE};
      tx_page_loaded_r <= 1'b0;
    end else begin
      tx_page_word_r <= tx_word_nxt;
      tx_page_loaded_r <= wr_transmit;
    end
  end

  // Received page stores
  reg_word_t partner_np_r; // Partner next page

  // Each page goes to the store matching its kind
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      partner_np_r <= `RST_WORD;
      partner_base_word_r <= `RST_WORD;
    end else if (rx_page_stb) begin
      if (rx_page_kind == PAGE_NEXT) begin
        partner_np_r <= rx_page_word;
      end else begin
        partner_base_word_r <= rx_page_word;
      end
    end
  end

  // Read mux
  reg_word_t rdata_nxt; // Value for the read port
  always_comb begin
    rdata_nxt = `RST_WORD;
    if (addr_hit(mgmt_addr, `AN_EXPANSION_OFFSET)) begin
      // Reserved upper bits read 0
      rdata_nxt[`EXP_BASE_PAGE_BIT] = base_page_r;
      rdata_nxt[`EXP_PAR_FAULT_BIT] = par_fault_r;
      rdata_nxt[`EXP_LP_NP_ABLE_BIT] = lp_np_able_r;
      rdata_nxt[`EXP_NP_ABLE_BIT] = local_np_able_r;
      rdata_nxt[`EXP_PAGE_RX_BIT] = page_rx_r;
      rdata_nxt[`EXP_LP_AN_ABLE_BIT] = lp_an_able_r;
    end else if (addr_hit(mgmt_addr, `NP_TRANSMIT_OFFSET)) begin
      rdata_nxt = tx_word_nxt;
    end else if (addr_hit(mgmt_addr, `PARTNER_NP_OFFSET)) begin
      rdata_nxt = partner_np_r;
    end
  end

  // Read data register, loaded on a read strobe, held otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata_r <= `RST_WORD;
    end else if (mgmt_rd) begin
      mgmt_rdata_r <= rdata_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_page_rx_set;
    rx_page_stb |=> page_rx_r;
  endproperty
  a_page_rx_set: assert property (p_page_rx_set) else $error("page flag not set");

  property p_page_rx_read_clr;
    rd_expansion && !rx_page_stb |=> !page_rx_r;
  endproperty
  a_page_rx_read_clr: assert property (p_page_rx_read_clr) else $error("page flag survived read");

  property p_alt_clear;
    alternate_next_page_enable && transmit_disable && !rx_page_stb |=> !page_rx_r;
  endproperty
  a_alt_clear: assert property (p_alt_clear) else $error("page flag not cleared");

  property p_base_gated;
    !alternate_next_page_enable |=> !base_page_r;
  endproperty
  a_base_gated: assert property (p_base_gated) else $error("base flag while disabled");

  property p_fault_hold;
    parallel_fault_evt ##1 !rd_expansion [*2] |=> par_fault_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

  property p_np_able_read;
    rd_expansion |=> mgmt_rdata_r[`EXP_NP_ABLE_BIT];
  endproperty
  a_np_able_read: assert property (p_np_able_read) else $error("local ability not 1");

  property p_toggle_flip;
    tx_page_sent |=> toggle_r != $past(toggle_r);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not invert");

  property p_np_store;
    rx_page_stb && rx_page_kind == PAGE_NEXT |=> partner_np_r == $past(rx_page_word);
  endproperty
  a_np_store: assert property (p_np_store) else $error("next page not stored");

  property p_tx_word;
    wr_transmit && !tx_page_sent |=> ##1
      tx_page_word_r == {$past(mgmt_wdata[15], 2), 1'b0, $past(mgmt_wdata[13:0], 2)};
  endproperty
  a_tx_word: assert property (p_tx_word) else $error("transmit word mismatch");

  property p_an_able;
    partner_an_able |=> lp_an_able_r;
  endproperty
  a_an_able: assert property (p_an_able) else $error("partner ability lost");

  property p_cov_next_page;
    rx_page_stb && rx_page_kind == PAGE_NEXT ##1 rd_expansion;
  endproperty
  c_cov_next_page: cover property (p_cov_next_page);

  property p_cov_set_on_read;
    rx_page_stb && rd_expansion;
  endproperty
  c_cov_set_on_read: cover property (p_cov_set_on_read);

  property p_cov_base;
    alternate_next_page_enable && base_page_variable ##1 base_page_r;
  endproperty
  c_cov_base: cover property (p_cov_base);

endmodule // autoneg_np_regs

`default_nettype wire

// [tb/mgmt_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Management controller: one strobe per access, held over the taking edge
module mgmt_ctl_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output var autoneg_np_pkg::reg_addr_t mgmt_addr,
  output var logic mgmt_wr,
  output var logic mgmt_rd,
  output var autoneg_np_pkg::reg_word_t mgmt_wdata,
  input wire autoneg_np_pkg::reg_word_t mgmt_rdata_r
);
  import autoneg_np_pkg::*;
  // Idle bus at time zero
  initial begin
    mgmt_addr = 5'h1F;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h5A5A;
  end
  // Write: the comply bit is whatever software decides to send
  task wr(input reg_addr_t a, input reg_word_t d);
    @(posedge core_clk);
    #1;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(posedge core_clk);
    #1;
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask
  // Read: data is taken at the edge that took the strobe
  task rd(input reg_addr_t a, output reg_word_t d);
    @(posedge core_clk);
    #1;
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(posedge core_clk);
    #1;
    d = mgmt_rdata_r;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
  endtask
endmodule // mgmt_ctl_model

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import autoneg_np_pkg::*;
  // Clock, reset, counters
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  integer seed = 32'ha316aa60;
  // Bench-driven design inputs
  logic alternate_next_page_enable = 1'b0;
  logic transmit_disable = 1'b0;
  logic page_arrived_variable = 1'b1;
  logic base_page_variable = 1'b0;
  logic parallel_fault_evt = 1'b0;
  logic partner_np_able = 1'b0;
  logic partner_an_able = 1'b0;
  logic rx_page_stb = 1'b0;
  page_kind_t rx_page_kind = PAGE_NEXT;
  reg_word_t rx_page_word = 16'h0000;
  logic tx_page_sent = 1'b0;
  // Register port and outputs
  reg_addr_t mgmt_addr;
  logic mgmt_wr;
  logic mgmt_rd;
  reg_word_t mgmt_wdata;
  reg_word_t mgmt_rdata_r;
  reg_word_t tx_page_word_r;
  logic tx_page_loaded_r;
  reg_word_t partner_base_word_r;
  reg_word_t w;

  always #20 core_clk = ~core_clk;

  mgmt_ctl_model MGR (.core_clk(core_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata_r(mgmt_rdata_r));

  autoneg_np_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_r(mgmt_rdata_r),
    .alternate_next_page_enable(alternate_next_page_enable), .transmit_disable(transmit_disable),
    .page_arrived_variable(page_arrived_variable), .base_page_variable(base_page_variable),
    .parallel_fault_evt(parallel_fault_evt), .partner_np_able(partner_np_able),
    .partner_an_able(partner_an_able), .rx_page_stb(rx_page_stb), .rx_page_kind(rx_page_kind),
    .rx_page_word(rx_page_word), .tx_page_sent(tx_page_sent), .tx_page_word_r(tx_page_word_r),
    .tx_page_loaded_r(tx_page_loaded_r), .partner_base_word_r(partner_base_word_r));

  // Transmit word as read back: bit 14 always reads 0
  function automatic reg_word_t tx_exp(input reg_word_t d);
    return d & 16'hBFFF;
  endfunction

  // Word comparison
  task chk(input string what, input reg_word_t exp, input reg_word_t got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // Register read and compare
  task rdchk(input reg_addr_t a, input reg_word_t exp, input string what);
    reg_word_t d;
    MGR.rd(a, d);
    chk(what, exp, d);
  endtask

  // Wait n edges, land just after the last
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle pulse on an engine input
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1;
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // Verdict
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    bad_count++;
    final_report;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    chk("tx word in reset", 16'h2001, tx_page_word_r);
    rst_n = 1'b1;
    rdchk(5'h06, 16'h0004, "expansion reset");
    rdchk(5'h07, 16'h2001, "np tx reset");
    chk("tx word reset", 16'h2001, tx_page_word_r);
    rdchk(5'h08, 16'h0000, "np rx reset");
    // Writes with corner and random words, writes to read-only places
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : reg_word_t'($random(seed));
      MGR.wr(5'h07, w);
      chk("tx loaded", 16'h0001, {15'h0000, tx_page_loaded_r});
      tick(1);
      chk("tx word", tx_exp(w), tx_page_word_r);
      rdchk(5'h07, tx_exp(w), "np tx read");
      MGR.wr(5'h08, w);
      MGR.wr(5'h06, ~w);
      rdchk(5'h08, 16'h0000, "np rx read only");
      rdchk(5'h1F, 16'h0000, "unmapped");
    end
    rdchk(5'h06, 16'h0004, "expansion read only");
    // Toggle flips after a transmitted word
    pulse(tx_page_sent);
    tick(1);
    chk("toggle", tx_exp(w) ^ 16'h0800, tx_page_word_r);
    // Next page received
    w = $random(seed);
    rx_page_word = w;
    pulse(rx_page_stb);
    rdchk(5'h08, w, "np rx word");
    rdchk(5'h06, 16'h0006, "page rx set");
    rdchk(5'h06, 16'h0004, "page rx cleared");
    // Base page while alternate mode is off
    w = $random(seed);
    rx_page_word = w;
    rx_page_kind = PAGE_BASE;
    base_page_variable = 1'b1;
    pulse(rx_page_stb);
    chk("base store", w, partner_base_word_r);
    rdchk(5'h06, 16'h0006, "base gated");
    // Base page with alternate mode on
    alternate_next_page_enable = 1'b1;
    pulse(rx_page_stb);
    base_page_variable = 1'b0;
    rdchk(5'h06, 16'h0026, "base flag");
    rdchk(5'h06, 16'h0004, "base cleared");
    // Page-received dropped by variable low or transmit disable
    rx_page_kind = PAGE_NEXT;
    for (int k = 0; k < 2; k++) begin
      page_arrived_variable = 1'b1;
      pulse(rx_page_stb);
      page_arrived_variable = (k == 1);
      transmit_disable = (k == 1);
      tick(2);
      rdchk(5'h06, 16'h0004, "page rx dropped");
    end
    transmit_disable = 1'b0;
    page_arrived_variable = 1'b1;
    // Parallel detection fault
    pulse(parallel_fault_evt);
    tick(2);
    rdchk(5'h06, 16'h0014, "fault set");
    rdchk(5'h06, 16'h0004, "fault cleared");
    // Partner abilities
    partner_np_able = 1'b1;
    partner_an_able = 1'b1;
    tick(2);
    rdchk(5'h06, 16'h000D, "partner able");
    // New page in the very cycle of a read: the read sees the old value, the set wins
    fork
      pulse(rx_page_stb);
      rdchk(5'h06, 16'h000D, "read during set");
    join
    rdchk(5'h06, 16'h000F, "set beats read clear");
    rdchk(5'h06, 16'h000D, "page rx cleared again");
    final_report;
  end
endmodule // tb_top

`default_nettype wire
